//--- logic/cbi_top.sv
// Processor bus data, cycle attribute, bus request and inquire port with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "cbi_regs.svh"
module cbi_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Cycle control pins
  output logic address_strobe_n,
  output logic bus_request_out,
  output logic bus_request_oe_n,
  output logic cacheable_n,
  output logic data_code,
  output logic attr_oe_n,
  output logic [7:0] byte_lane_enables,
  input wire logic burst_ready_n,
  input wire logic burst_ready_copy_n,
  input wire logic next_address_n,
  input wire logic cache_enable_in_n,
  input wire logic backoff_n,
  input wire logic address_hold,
  // Data and parity pins
  input wire logic [63:0] data_in,
  output logic [63:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] data_parity_in,
  output logic [7:0] data_parity_out,
  output logic data_parity_oe_n,
  output logic parity_check_n,
  // Inquire
  input wire logic external_address_strobe_n,
  output logic inquire_lookup,
  input wire logic lookup_hit,
  input wire logic lookup_modified,
  output logic inquire_hit_n,
  output logic inquire_modified_match_n,
  // Neighbouring core logic
  input wire logic hold_acknowledge,
  input wire logic float_test_mode,
  output logic drive_strength_high
);
  cbi_mem_if #(.AW(2)) mem_bus ();

  cbi_beat_mem #(.DEPTH(4), .AW(2)) u_mem (
    .hclk(hclk),
    .m(mem_bus.mem)
  );

  // Pin inputs pass two flip-flops; strobes idle high.
  logic [78:0] sync1_ff;
  logic [78:0] sync2_ff;
  logic burst_ready_n_sn, burst_ready_copy_n_sn, na_sn, ken_sn, backoff_n_sn, address_hold_s, external_address_strobe_n_sn;
  logic [63:0] data_s;
  logic [7:0] dp_s;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= {`CBI_PIN_IDLE, 72'h0};
      sync2_ff <= {`CBI_PIN_IDLE, 72'h0};
    end else begin
      sync1_ff <= {external_address_strobe_n, address_hold, backoff_n, cache_enable_in_n,
                   next_address_n, burst_ready_copy_n, burst_ready_n, data_parity_in, data_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign {external_address_strobe_n_sn, address_hold_s, backoff_n_sn, ken_sn, na_sn, burst_ready_copy_n_sn, burst_ready_n_sn, dp_s, data_s} = sync2_ff;

  // Drive strength strap, taken once the synchroniser holds the pin value.
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic strong_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      strong_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == `CBI_STRAP_WAIT) begin
        strong_ff <= ~burst_ready_copy_n_sn;
        strap_done_ff <= 1'b1;
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end
  assign drive_strength_high = strong_ff;

  // AHB address phase.
  logic ap_valid_ff, ap_write_ff, rd_ok_ff;
  logic [7:0] ap_addr_ff;
  logic dreg, dphase, stall, ctrl_wr, stat_wr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_ff <= 1'b0;
      ap_write_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
    end else if (hready) begin
      ap_valid_ff <= hsel & htrans[1];
      ap_write_ff <= hwrite;
      ap_addr_ff <= haddr[7:0];
    end
  end

  cbi_pkg::cbi_state_t state_ff, nxt_state;
  logic busy;
  assign busy = state_ff != cbi_pkg::ST_IDLE;
  assign dreg = ap_valid_ff & (ap_addr_ff[7:5] == `CBI_DATA_REGION);
  // The beat memory belongs to the bus while a cycle runs, so data accesses wait.
  assign stall = dreg & (busy | (~ap_write_ff & ~rd_ok_ff));
  assign hreadyout = ~stall;
  assign hresp = 1'b0;
  assign dphase = ap_valid_ff & ~stall;
  assign ctrl_wr = dphase & ap_write_ff & (ap_addr_ff == `CBI_OFF_CTRL);
  assign stat_wr = dphase & ap_write_ff & (ap_addr_ff == `CBI_OFF_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ok_ff <= 1'b0;
    end else begin
      rd_ok_ff <= dreg & ~ap_write_ff & ~busy & ~rd_ok_ff;
    end
  end

  // Cycle set-up written by software.
  logic wr_ff, cache_req_ff, dc_req_ff, start, cancel;
  logic [7:0] be_ff;
  assign start = ctrl_wr & ~busy & hwdata[`CBI_CTRL_START];
  assign cancel = ctrl_wr & hwdata[`CBI_CTRL_CANCEL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      cache_req_ff <= 1'b0;
      dc_req_ff <= 1'b0;
      be_ff <= `CBI_BE_RST;
    end else if (ctrl_wr & ~busy) begin
      wr_ff <= hwdata[`CBI_CTRL_WRITE];
      cache_req_ff <= hwdata[`CBI_CTRL_CACHE];
      dc_req_ff <= hwdata[`CBI_CTRL_DATA];
      be_ff <= hwdata[`CBI_CTRL_BE_LO +: 8];
    end
  end
  assign byte_lane_enables = ~be_ff;

  // Bus cycle sequencing.
  logic rdy, grant, last, burst_now, ken_done_ff, burst_ff;
  logic [1:0] beat_ff, nxt_beat;
  assign rdy = ~burst_ready_n_sn | ~burst_ready_copy_n_sn;
  assign grant = backoff_n_sn & ~hold_acknowledge & ~address_hold_s;
  assign burst_now = wr_ff ? cache_req_ff :
                     (ken_done_ff ? burst_ff : cache_req_ff & ~ken_sn);
  assign last = beat_ff == (burst_now ? `CBI_LAST_BURST : `CBI_LAST_SINGLE);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cbi_pkg::ST_IDLE: begin
        if (start) begin
          nxt_state = cbi_pkg::ST_REQ;
        end
      end
      cbi_pkg::ST_REQ: begin
        if (cancel) begin
          nxt_state = cbi_pkg::ST_IDLE;
        end else if (grant) begin
          nxt_state = cbi_pkg::ST_ADDR;
        end
      end
      cbi_pkg::ST_ADDR: begin
        nxt_state = backoff_n_sn ? cbi_pkg::ST_DATA : cbi_pkg::ST_REQ;
      end
      cbi_pkg::ST_DATA: begin
        // Backoff beats a ready on the same edge and restarts the cycle.
        if (!backoff_n_sn) begin
          nxt_state = cbi_pkg::ST_REQ;
        end else if (rdy && last) begin
          nxt_state = cbi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= cbi_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  logic in_data;
  assign in_data = (state_ff == cbi_pkg::ST_DATA) & backoff_n_sn;
  assign nxt_beat = (state_ff != cbi_pkg::ST_DATA || !backoff_n_sn) ? 2'h0 :
                    (rdy ? beat_ff + 2'h1 : beat_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beat_ff <= 2'h0;
      ken_done_ff <= 1'b0;
      burst_ff <= 1'b0;
    end else begin
      beat_ff <= nxt_beat;
      if (!in_data) begin
        ken_done_ff <= 1'b0;
      end else if ((rdy || !na_sn) && !ken_done_ff) begin
        ken_done_ff <= 1'b1;
        burst_ff <= burst_now;
      end
    end
  end

  // Strobe and bus request.
  logic ads_n_ff, bus_request_out_ff, to_addr;
  assign to_addr = (state_ff == cbi_pkg::ST_REQ) & (nxt_state == cbi_pkg::ST_ADDR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ads_n_ff <= 1'b1;
      bus_request_out_ff <= 1'b0;
    end else begin
      ads_n_ff <= ~to_addr;
      bus_request_out_ff <= (nxt_state == cbi_pkg::ST_REQ) | to_addr;
    end
  end
  assign address_strobe_n = ads_n_ff;
  assign bus_request_out = bus_request_out_ff;
  assign bus_request_oe_n = float_test_mode;

  // Cycle attributes.
  logic cache_n_ff, dc_ff, float_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cache_n_ff <= 1'b1;
      dc_ff <= 1'b0;
      float_ff <= 1'b0;
    end else begin
      float_ff <= ~backoff_n_sn;
      if (to_addr) begin
        cache_n_ff <= ~cache_req_ff;
        dc_ff <= dc_req_ff;
      end else if (in_data && (!na_sn || (rdy && last))) begin
        cache_n_ff <= 1'b1;
      end
    end
  end
  assign cacheable_n = cache_n_ff;
  assign data_code = dc_ff;
  assign attr_oe_n = float_ff | hold_acknowledge;

  // Write driving window.
  logic drive_n_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_n_ff <= 1'b1;
    end else begin
      // One cycle at a time means any earlier read has seen its last ready already.
      drive_n_ff <= ~(wr_ff & (nxt_state == cbi_pkg::ST_DATA) & backoff_n_sn);
    end
  end
  assign data_oe_n = drive_n_ff | hold_acknowledge;
  assign data_parity_oe_n = drive_n_ff | hold_acknowledge;
  assign data_out = {mem_bus.rdata_hi.data, mem_bus.rdata_lo.data};
  assign data_parity_out = {mem_bus.rdata_hi.par, mem_bus.rdata_lo.par};

  // Parity over each byte lane.
  logic [7:0] par_bad;
  logic [3:0] wpar;
  for (genvar i = 0; i < 8; i++) begin : g_lane
    assign par_bad[i] = ^{data_s[8*i +: 8], dp_s[i]};
    if (i < 4) begin : g_wpar
      assign wpar[i] = ^hwdata[8*i +: 8];
    end
  end

  // Beat memory access.
  logic cap;
  assign cap = in_data & ~wr_ff & rdy;
  assign mem_bus.raddr = busy ? nxt_beat : ap_addr_ff[4:3];
  assign mem_bus.waddr = cap ? beat_ff : ap_addr_ff[4:3];
  assign mem_bus.we_lo = cap | (dphase & dreg & ap_write_ff & ~ap_addr_ff[2]);
  assign mem_bus.we_hi = cap | (dphase & dreg & ap_write_ff & ap_addr_ff[2]);
  assign mem_bus.wdata_lo = cap ? {data_s[31:0], dp_s[3:0]} : {hwdata, wpar};
  assign mem_bus.wdata_hi = cap ? {data_s[63:32], dp_s[7:4]} : {hwdata, wpar};

  // Read parity check, one clock after the capture edge.
  logic perr_pend_ff, parity_check_n_n_ff, perr_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perr_pend_ff <= 1'b0;
      parity_check_n_n_ff <= 1'b1;
    end else begin
      perr_pend_ff <= cap & |(par_bad & (burst_now ? 8'hff : be_ff));
      parity_check_n_n_ff <= ~perr_pend_ff;
    end
  end
  assign parity_check_n = parity_check_n_n_ff;

  // Sticky error flag; a new error wins over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      perr_ff <= 1'b0;
    end else if (perr_pend_ff) begin
      perr_ff <= 1'b1;
    end else if (stat_wr && hwdata[`CBI_STAT_PERR]) begin
      perr_ff <= 1'b0;
    end
  end

  // Inquire strobe qualification and hit reporting.
  logic [1:0] take_cnt_ff;
  logic ads_seen_ff, lookup_ff, hit_n_ff, inquire_modified_match_n_n_ff, external_address_strobe_n_ok, take;
  assign take = address_hold_s | ~backoff_n_sn | hold_acknowledge;
  assign external_address_strobe_n_ok = ~external_address_strobe_n_sn & (take_cnt_ff == `CBI_EXTERNAL_ADDRESS_STROBE_N_DELAY)
                   & ~lookup_ff & ~ads_seen_ff & inquire_modified_match_n_n_ff
                   & ~((state_ff == cbi_pkg::ST_ADDR || state_ff == cbi_pkg::ST_DATA)
                       & grant);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      take_cnt_ff <= 2'h0;
      ads_seen_ff <= 1'b0;
      lookup_ff <= 1'b0;
      hit_n_ff <= 1'b1;
      inquire_modified_match_n_n_ff <= 1'b1;
    end else begin
      if (!take) begin
        take_cnt_ff <= 2'h0;
      end else if (take_cnt_ff != `CBI_EXTERNAL_ADDRESS_STROBE_N_DELAY) begin
        take_cnt_ff <= take_cnt_ff + 2'h1;
      end
      ads_seen_ff <= ~ads_n_ff;
      lookup_ff <= external_address_strobe_n_ok;
      if (lookup_ff) begin
        hit_n_ff <= ~lookup_hit;
        inquire_modified_match_n_n_ff <= ~lookup_modified;
      end
    end
  end
  assign inquire_lookup = lookup_ff;
  assign inquire_hit_n = hit_n_ff;
  assign inquire_modified_match_n = inquire_modified_match_n_n_ff;

  // Register read data.
  always_comb begin
    hrdata = 32'h0;
    if (dreg) begin
      hrdata = ap_addr_ff[2] ? mem_bus.rdata_hi.data : mem_bus.rdata_lo.data;
    end else if (ap_valid_ff && ap_addr_ff == `CBI_OFF_CTRL) begin
      hrdata[`CBI_CTRL_WRITE] = wr_ff;
      hrdata[`CBI_CTRL_CACHE] = cache_req_ff;
      hrdata[`CBI_CTRL_DATA] = dc_req_ff;
      hrdata[`CBI_CTRL_BE_LO +: 8] = be_ff;
    end else if (ap_valid_ff && ap_addr_ff == `CBI_OFF_STATUS) begin
      hrdata[`CBI_STAT_BUSY] = busy;
      hrdata[`CBI_STAT_BURST] = burst_ff;
      hrdata[`CBI_STAT_STRONG] = strong_ff;
      hrdata[`CBI_STAT_PERR] = perr_ff;
      hrdata[`CBI_STAT_HIT] = ~hit_n_ff;
      hrdata[`CBI_STAT_INQUIRE_MODIFIED_MATCH_N] = ~inquire_modified_match_n_n_ff;
      hrdata[`CBI_STAT_BEAT_LO +: 2] = beat_ff;
    end
  end

  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8]};
endmodule
`default_nettype wire

//--- logic/cbi_regs.svh
// Register offsets, field positions, reset values and counts of the bus data and inquire port.
`ifndef CBI_REGS_SVH
`define CBI_REGS_SVH

`define CBI_OFF_CTRL 8'h00
`define CBI_OFF_STATUS 8'h04
`define CBI_DATA_REGION 3'h1
`define CBI_CTRL_START 0
`define CBI_CTRL_WRITE 1
`define CBI_CTRL_CACHE 2
`define CBI_CTRL_DATA 3
`define CBI_CTRL_CANCEL 6
`define CBI_CTRL_BE_LO 8
`define CBI_STAT_BUSY 0
`define CBI_STAT_BURST 1
`define CBI_STAT_STRONG 2
`define CBI_STAT_PERR 3
`define CBI_STAT_HIT 4
`define CBI_STAT_INQUIRE_MODIFIED_MATCH_N 5
`define CBI_STAT_BEAT_LO 8
`define CBI_BE_RST 8'hff
`define CBI_PIN_IDLE 7'h5f
`define CBI_LAST_BURST 2'h3
`define CBI_LAST_SINGLE 2'h0
`define CBI_EXTERNAL_ADDRESS_STROBE_N_DELAY 2'h2
`define CBI_STRAP_WAIT 2'h2
`define CBI_BURST_BEATS 4

`endif

//--- logic/cbi_pkg.sv
// Types shared by the bus data and inquire port.
package cbi_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA} cbi_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] par;
  } cbi_half_t;

endpackage

//--- logic/cbi_mem_if.sv
// Connection between the port logic and its beat memory.
`timescale 1ns/1ps
`default_nettype none
interface cbi_mem_if #(parameter int AW = 2);
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic we_lo;
  logic we_hi;
  cbi_pkg::cbi_half_t wdata_lo;
  cbi_pkg::cbi_half_t wdata_hi;
  cbi_pkg::cbi_half_t rdata_lo;
  cbi_pkg::cbi_half_t rdata_hi;
  modport ctrl (output waddr, raddr, we_lo, we_hi, wdata_lo, wdata_hi, input rdata_lo, rdata_hi);
  modport mem (input waddr, raddr, we_lo, we_hi, wdata_lo, wdata_hi, output rdata_lo, rdata_hi);
endinterface
`default_nettype wire

//--- logic/cbi_beat_mem.sv
// Beat memory holding data and parity of each transfer of a bus cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cbi_regs.svh"
module cbi_beat_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock
  input wire logic hclk,
  // Access port
  cbi_mem_if.mem m
);
  cbi_pkg::cbi_half_t lo_mem [DEPTH];
  cbi_pkg::cbi_half_t hi_mem [DEPTH];

  // A cache line needs one entry per transfer of a burst.
  if (DEPTH < `CBI_BURST_BEATS || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("cbi_beat_mem: DEPTH does not fit a burst or the address width");
  end

  always_ff @(posedge hclk) begin
    if (m.we_lo) begin
      lo_mem[m.waddr] <= m.wdata_lo;
    end
    if (m.we_hi) begin
      hi_mem[m.waddr] <= m.wdata_hi;
    end
  end

  always_ff @(posedge hclk) begin
    m.rdata_lo <= lo_mem[m.raddr];
    m.rdata_hi <= hi_mem[m.raddr];
  end
endmodule
`default_nettype wire

//--- verif/cbi_top_monitor.sv
// Concurrent checks on the pins of the bus data and inquire port.
`timescale 1ns/1ps
`default_nettype none
module cbi_top_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched pins
  input wire logic address_strobe_n,
  input wire logic bus_request_out,
  input wire logic bus_request_oe_n,
  input wire logic float_test_mode,
  input wire logic cacheable_n,
  input wire logic data_code,
  input wire logic attr_oe_n,
  input wire logic hold_acknowledge,
  input wire logic [63:0] data_out,
  input wire logic data_oe_n,
  input wire logic [7:0] data_parity_out,
  input wire logic data_parity_oe_n,
  input wire logic parity_check_n,
  input wire logic inquire_lookup,
  input wire logic inquire_hit_n,
  input wire logic inquire_modified_match_n,
  input wire logic drive_strength_high
);
  logic [2:0] rel_cnt_ff;
  logic [7:0] even_par;
  // Edges since reset release; the strength choice settles by the third.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rel_cnt_ff <= 3'h0;
    end else if (rel_cnt_ff != 3'h7) begin
      rel_cnt_ff <= rel_cnt_ff + 3'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      even_par[i] = ^data_out[8*i +: 8];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  req_strobe_a: assert property (!address_strobe_n |-> bus_request_out)
    else $error("bus request low with address strobe");
  req_float_a: assert property (bus_request_oe_n == float_test_mode)
    else $error("bus request enable wrong");
  parity_check_n_pulse_a: assert property (!parity_check_n |=> parity_check_n)
    else $error("parity check longer than one clock");
  strength_fixed_a: assert property (rel_cnt_ff > 3'h3 |-> $stable(drive_strength_high))
    else $error("drive strength changed");
  data_parity_a: assert property (!data_oe_n |-> data_parity_out == even_par)
    else $error("write parity not even");
  hit_cause_a: assert property ($changed({inquire_hit_n, inquire_modified_match_n})
    |-> $past(inquire_lookup) || $past(inquire_lookup, 2))
    else $error("hit outputs changed without lookup");
  hold_float_a: assert property (hold_acknowledge |-> attr_oe_n && data_oe_n)
    else $error("pins driven during hold acknowledge");
  attr_hold_a: assert property (!address_strobe_n |=> $stable({cacheable_n, data_code}))
    else $error("attributes moved after strobe");
  data_start_a: assert property ($fell(data_oe_n) |-> !$past(address_strobe_n))
    else $error("data driven without preceding strobe");
  par_lanes_a: assert property (data_parity_oe_n == data_oe_n)
    else $error("parity enable differs from data enable");
endmodule
bind cbi_top cbi_top_monitor cbi_top_monitor_inst (.hclk, .hresetn, .address_strobe_n,
  .bus_request_out, .bus_request_oe_n, .float_test_mode, .cacheable_n, .data_code, .attr_oe_n,
  .hold_acknowledge, .data_out, .data_oe_n, .data_parity_out, .data_parity_oe_n,
  .parity_check_n, .inquire_lookup, .inquire_hit_n, .inquire_modified_match_n,
  .drive_strength_high);
`default_nettype wire

//--- verif/cbi_sys_model.sv
// Behavioural system logic answering the bus cycles of the port.
`timescale 1ns/1ps
`default_nettype none
module cbi_sys_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench controls
  input wire logic strap,
  input wire logic [2:0] nb,
  input wire logic ken,
  input wire logic bad,
  input wire logic use_copy,
  input wire logic [1:0] dly,
  input wire logic [63:0] rbase,
  // Port pins
  input wire logic address_strobe_n,
  input wire logic cacheable_n,
  input wire logic data_code,
  input wire logic [7:0] byte_lane_enables,
  input wire logic [63:0] data_out,
  input wire logic [7:0] data_parity_out,
  output logic burst_ready_n,
  output logic burst_ready_copy_n,
  output logic next_address_n,
  output logic cache_enable_in_n,
  output logic [63:0] data_in,
  output logic [7:0] data_parity_in
);
  logic [63:0] cap_d [4];
  logic [7:0] cap_p [4];
  logic [9:0] cap_attr;
  logic [63:0] rd;
  int hold;
  function automatic logic [7:0] par(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      par[i] = ^d[8*i +: 8];
    end
  endfunction
  initial begin
    {burst_ready_n, burst_ready_copy_n, next_address_n, cache_enable_in_n} = 4'hf;
    {data_in, data_parity_in} = '0;
    hold = 0;
    forever begin
      @(negedge hclk);
      if (!hresetn || hold > 0) begin
        hold = hresetn ? hold - 1 : 4;
        @(posedge hclk);
        burst_ready_copy_n <= (hold == 0) ? 1'b1 : strap;
      end else if (address_strobe_n === 1'b0) begin
        cap_attr = {cacheable_n, data_code, byte_lane_enables};
        @(posedge hclk);
        cache_enable_in_n <= ken;
        repeat (int'(dly) + 1) @(posedge hclk);
        for (int i = 0; i < int'(nb); i++) begin
          @(negedge hclk);
          cap_d[i] = data_out;
          cap_p[i] = data_parity_out;
          rd = rbase + 64'(i);
          @(posedge hclk);
          if (use_copy) burst_ready_copy_n <= 1'b0;
          else burst_ready_n <= 1'b0;
          data_in <= rd;
          data_parity_in <= par(rd) ^ {7'h0, bad && i == 0};
          @(posedge hclk);
          {burst_ready_n, burst_ready_copy_n} <= 2'h3;
          // A released bus shows the inverse so stale data can never pass as fresh.
          data_in <= ~rd;
          data_parity_in <= ~data_parity_in;
          repeat (3) @(posedge hclk);
        end
        cache_enable_in_n <= ~ken;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/cbi_top_tb.sv
// Self-checking bench of the bus data and inquire port.
`timescale 1ns/1ps
`default_nettype none
module cbi_top_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, strap, ken, bad, use_copy;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0] htrans, dly;
  logic [2:0] hsize, nb;
  logic [63:0] data_in, data_out, rbase;
  logic [7:0] byte_lane_enables, data_parity_in, data_parity_out;
  logic address_strobe_n, bus_request_out, bus_request_oe_n, cacheable_n, data_code, attr_oe_n;
  logic burst_ready_n, burst_ready_copy_n, next_address_n, cache_enable_in_n, backoff_n;
  logic address_hold, data_oe_n, data_parity_oe_n, parity_check_n, external_address_strobe_n;
  logic inquire_lookup, lookup_hit, lookup_modified, inquire_hit_n, inquire_modified_match_n;
  logic hold_acknowledge, float_test_mode, drive_strength_high;
  int errors, compares, seed, cyc, pcnt, bo_cnt, bo_bad;
  cbi_top cbi_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .address_strobe_n, .bus_request_out,
    .bus_request_oe_n, .cacheable_n, .data_code, .attr_oe_n, .byte_lane_enables,
    .burst_ready_n, .burst_ready_copy_n, .next_address_n, .cache_enable_in_n, .backoff_n,
    .address_hold, .data_in, .data_out, .data_oe_n, .data_parity_in, .data_parity_out,
    .data_parity_oe_n, .parity_check_n, .external_address_strobe_n, .inquire_lookup,
    .lookup_hit, .lookup_modified, .inquire_hit_n, .inquire_modified_match_n,
    .hold_acknowledge, .float_test_mode, .drive_strength_high);
  cbi_sys_model cbi_sys_model_inst (.hclk, .hresetn, .strap, .nb, .ken, .bad, .use_copy, .dly,
    .rbase, .address_strobe_n, .cacheable_n, .data_code, .byte_lane_enables, .data_out,
    .data_parity_out, .burst_ready_n, .burst_ready_copy_n, .next_address_n,
    .cache_enable_in_n, .data_in, .data_parity_in);
  always #20 hclk = ~hclk;
  function automatic logic [7:0] par(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      par[i] = ^d[8*i +: 8];
    end
  endfunction
  function automatic logic [63:0] lanes(input logic [7:0] be);
    for (int j = 0; j < 8; j++) begin
      lanes[8*j +: 8] = {8{be[j]}};
    end
  endfunction
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Ready is looked at on the falling edge so the rising edge never races the slave.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic do_reset(input logic s);
    @(posedge hclk);
    strap <= s;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    check("strength", 64'(drive_strength_high), 64'(!s));
  endtask
  task automatic run_cycle(input logic wr, input logic cch, input logic k, input logic b);
    logic [63:0] wd [4];
    logic [63:0] m;
    logic [31:0] st;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [7:0] be;
    logic dc;
    int n;
    n = (wr ? cch : cch && !k) ? 4 : 1;
    be = 8'($random(seed)) | {7'h0, b};
    dc = 1'($random(seed));
    m = (n == 4) ? 64'hffffffffffffffff : lanes(be);
    for (int i = 0; i < n; i++) begin
      wd[i] = {$random(seed), $random(seed)};
      if (wr) begin
        ahb(1'b1, 32'h20 + 32'(8 * i), wd[i][31:0], st);
        ahb(1'b1, 32'h24 + 32'(8 * i), wd[i][63:32], st);
      end
    end
    nb <= 3'(n);
    ken <= k;
    bad <= b;
    use_copy <= 1'($random(seed));
    dly <= 2'($random(seed));
    rbase <= wd[0];
    pcnt = 0;
    ahb(1'b1, 32'h0, {16'h0, be, 4'h0, dc, cch, wr, 1'b1}, st);
    for (int t = 0; t < 80; t++) begin
      ahb(1'b0, 32'h4, 32'h0, st);
      if (st[0] === 1'b0) break;
    end
    // The error flag and the parity pulse trail the last ready, so let them settle first.
    repeat (3) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0, st);
    check("busy", 64'(st[0]), 64'h0);
    check("burst", 64'(st[1]), 64'(n == 4));
    check("perr", 64'(st[3]), 64'(b));
    check("parity_check_n", 64'(pcnt), 64'(b));
    check("attr", 64'(cbi_sys_model_inst.cap_attr), 64'({!cch, dc, ~be}));
    if (b) ahb(1'b1, 32'h4, 32'h8, st);
    for (int i = 0; i < n; i++) begin
      if (wr) begin
        check("wdata", cbi_sys_model_inst.cap_d[i] & m, wd[i] & m);
        check("wpar", 64'(cbi_sys_model_inst.cap_p[i]), 64'(par(wd[i])));
      end else begin
        ahb(1'b0, 32'h20 + 32'(8 * i), 32'h0, lo);
        ahb(1'b0, 32'h24 + 32'(8 * i), 32'h0, hi);
        check("rdata", {hi, lo} & m, (wd[0] + 64'(i)) & m);
      end
    end
  endtask
  task automatic inquire(input logic take, input logic acc, input logic hit, input logic mod);
    logic exp_h;
    logic exp_m;
    exp_h = acc ? !hit : inquire_hit_n;
    exp_m = acc ? !mod : inquire_modified_match_n;
    @(posedge hclk);
    address_hold <= take;
    lookup_hit <= hit;
    lookup_modified <= mod;
    repeat (4) @(posedge hclk);
    external_address_strobe_n <= 1'b0;
    @(posedge hclk);
    external_address_strobe_n <= 1'b1;
    repeat (6) @(posedge hclk);
    check("hit", 64'(inquire_hit_n), 64'(exp_h));
    check("inquire_modified_match_n", 64'(inquire_modified_match_n), 64'(exp_m));
    address_hold <= 1'b0;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (bo_cnt > 0) bo_cnt <= bo_cnt - 1;
    if (bo_cnt == 1) backoff_n <= 1'b1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  always @(negedge hclk) begin
    if (parity_check_n === 1'b0) pcnt++;
    if (bo_cnt > 0 && bo_cnt < 40) bo_bad += int'(!bus_request_out || !address_strobe_n);
    if (bo_cnt > 0 && bo_cnt < 40) bo_bad += int'(attr_oe_n !== 1'b1);
  end
  initial begin
    seed = 48;
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, address_hold, lookup_hit} = '0;
    {lookup_modified, hold_acknowledge, float_test_mode, nb, ken, bad, use_copy, dly} = '0;
    {backoff_n, external_address_strobe_n, rbase, strap} = {2'h3, 64'h0, 1'b1};
    hsize = 3'h2;
    do_reset(1'($random(seed)));
    run_cycle(1'b0, 1'b0, 1'b0, 1'b1);
    run_cycle(1'b0, 1'b1, 1'b0, 1'b1);
    run_cycle(1'b0, 1'b1, 1'b1, 1'b0);
    run_cycle(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (12) begin
      run_cycle(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b0);
    end
    do_reset(!strap);
    @(posedge hclk);
    backoff_n <= 1'b0;
    bo_cnt <= 60;
    ahb(1'b1, 32'h0, 32'h1, st);
    ahb(1'b1, 32'h0, 32'h40, st);
    ahb(1'b0, 32'h4, 32'h0, st);
    check("cancel", 64'({st[0], bus_request_out, hresp}), 64'h0);
    run_cycle(1'b1, 1'b0, 1'b0, 1'b0);
    check("req_held", 64'(bo_bad), 64'h0);
    @(posedge hclk);
    hold_acknowledge <= 1'b1;
    float_test_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    hold_acknowledge <= 1'b0;
    float_test_mode <= 1'b0;
    inquire(1'b1, 1'b1, 1'b1, 1'b0);
    inquire(1'b0, 1'b0, 1'b0, 1'b0);
    inquire(1'b1, 1'b1, 1'b0, 1'b0);
    inquire(1'b1, 1'b1, 1'b1, 1'b1);
    inquire(1'b1, 1'b0, 1'b0, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
